// ==== core/gpx_pkg.sv ====
// Purpose: shared constants for the gpio port and external line controller
// Assumes: 32-bit register words, byte addresses on a 12-bit address port
// Notes: per-port register groups repeat every 0x40 bytes below 0x400
package gpx_pkg;
  // ************************************************************
  // geometry
  // ************************************************************
  localparam int PINS = 16;
  localparam int NLINE = 23;
  localparam int NGPIO_LINE = 16;
  localparam int NINT_LINE = 7;
  localparam int AW = 12;
  localparam int PORT_SH = 6;
  // ************************************************************
  // per-port register offsets, low six address bits
  // ************************************************************
  localparam logic [5:0] OFS_MODE = 6'h00;
  localparam logic [5:0] OFS_OTYPE = 6'h04;
  localparam logic [5:0] OFS_PULL = 6'h08;
  localparam logic [5:0] OFS_ODATA = 6'h0c;
  localparam logic [5:0] OFS_IDATA = 6'h10;
  localparam logic [5:0] OFS_TOGGLE = 6'h14;
  localparam logic [5:0] OFS_AFLO = 6'h18;
  localparam logic [5:0] OFS_AFHI = 6'h1c;
  localparam logic [5:0] OFS_LOCK = 6'h20;
  // ************************************************************
  // external line controller, selected by this address bit alone
  // ************************************************************
  localparam int EXT_BIT = 10;
  localparam logic [5:0] OFS_IMASK = 6'h00;
  localparam logic [5:0] OFS_EMASK = 6'h04;
  localparam logic [5:0] OFS_RISE = 6'h08;
  localparam logic [5:0] OFS_FALL = 6'h0c;
  localparam logic [5:0] OFS_PEND = 6'h10;
  localparam logic [5:0] OFS_SRCLO = 6'h14;
  localparam logic [5:0] OFS_SRCHI = 6'h18;
  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int LOCK_KEY = 16;
  localparam int LOCK_ACT = 17;
  localparam logic [1:0] MODE_IN = 2'h0;
  localparam logic [1:0] MODE_OUT = 2'h1;
  localparam logic [1:0] MODE_ALT = 2'h2;
  localparam logic [1:0] MODE_ANA = 2'h3;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DN = 2'h2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [22:0] RST_LINE = 23'h00_0000;
  typedef enum logic [2:0] {
    GPX_LK_IDLE = 3'b001,
    GPX_LK_ONE = 3'b010,
    GPX_LK_ZERO = 3'b100
  } gpx_lock_t;
endpackage

// ==== core/gpx_top.sv ====
// Purpose: gpio ports with locking and remap, plus the external line event controller
// Assumes: one 20 MHz clock, pin and event inputs synchronous to it
// Notes: read data appear the cycle after the read strobe; unmapped reads give zero
`timescale 1ns/1ps
module gpx_top #(
  parameter int NPORT = 6,
  parameter int NALT = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [gpx_pkg::AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pins
  input wire logic [NPORT*gpx_pkg::PINS-1:0] pin_in,
  output logic [NPORT*gpx_pkg::PINS-1:0] pin_out,
  output logic [NPORT*gpx_pkg::PINS-1:0] pin_oe,
  output logic [NPORT*gpx_pkg::PINS-1:0] pull_up_en,
  output logic [NPORT*gpx_pkg::PINS-1:0] pull_dn_en,
  // alternate functions, NALT sources per pin
  input wire logic [NPORT*gpx_pkg::PINS*NALT-1:0] alt_out,
  input wire logic [NPORT*gpx_pkg::PINS*NALT-1:0] alt_oe,
  // internal event sources and line requests
  input wire logic [gpx_pkg::NINT_LINE-1:0] int_evt,
  output logic [gpx_pkg::NLINE-1:0] irq_req,
  output logic [gpx_pkg::NLINE-1:0] evt_req
);
  localparam int P = gpx_pkg::PINS;

  // port numbers and alternate selections are 4-bit fields, so sixteen is the ceiling
  if (NPORT < 1 || NPORT > 16 || NALT < 1 || NALT > 16) begin : g_bad_size
    $error("gpx_top: NPORT and NALT must lie in 1..16");
  end

  // ************************************************************
  // address decode
  // ************************************************************
  logic ext_sel;
  logic [3:0] port_idx;
  logic [5:0] ofs;
  // address bit 11 is not decoded, so the map repeats above it
  assign ext_sel = addr[gpx_pkg::EXT_BIT];
  assign port_idx = addr[gpx_pkg::EXT_BIT-1:gpx_pkg::PORT_SH];
  assign ofs = addr[5:0];

  logic [31:0] mode_reg [NPORT];
  logic [15:0] otype_reg [NPORT];
  logic [31:0] pull_reg [NPORT];
  logic [15:0] odata_reg [NPORT];
  logic [31:0] aflo_reg [NPORT];
  logic [31:0] afhi_reg [NPORT];
  logic [15:0] lck_reg [NPORT];
  logic lck_act_reg [NPORT];

  function automatic logic [31:0] spread2(input logic [15:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      r[2*i +: 2] = {2{m[i]}};
    end
    return r;
  endfunction

  function automatic logic [31:0] spread4(input logic [7:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      r[4*i +: 4] = {4{m[i]}};
    end
    return r;
  endfunction

  // ************************************************************
  // per-port configuration, lock and pin drive
  // ************************************************************
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic psel;
    logic [15:0] frz;
    gpx_pkg::gpx_lock_t lk_reg;
    assign psel = wr && !ext_sel && port_idx == 4'(p);
    // frozen pins ignore configuration writes
    assign frz = lck_act_reg[p] ? lck_reg[p] : 16'h0000;

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        mode_reg[p] <= gpx_pkg::RST_WORD;
        otype_reg[p] <= gpx_pkg::RST_HALF;
        pull_reg[p] <= gpx_pkg::RST_WORD;
      end else if (psel) begin
        if (ofs == gpx_pkg::OFS_MODE) begin
          mode_reg[p] <= (mode_reg[p] & spread2(frz)) | (wdata & ~spread2(frz));
        end
        if (ofs == gpx_pkg::OFS_OTYPE) begin
          otype_reg[p] <= (otype_reg[p] & frz) | (wdata[15:0] & ~frz);
        end
        if (ofs == gpx_pkg::OFS_PULL) begin
          pull_reg[p] <= (pull_reg[p] & spread2(frz)) | (wdata & ~spread2(frz));
        end
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        aflo_reg[p] <= gpx_pkg::RST_WORD;
        afhi_reg[p] <= gpx_pkg::RST_WORD;
      end else if (psel) begin
        if (ofs == gpx_pkg::OFS_AFLO) begin
          aflo_reg[p] <= (aflo_reg[p] & spread4(frz[7:0])) | (wdata & ~spread4(frz[7:0]));
        end
        if (ofs == gpx_pkg::OFS_AFHI) begin
          afhi_reg[p] <= (afhi_reg[p] & spread4(frz[15:8])) | (wdata & ~spread4(frz[15:8]));
        end
      end
    end

    // output data stays writable under lock; toggle flips in one cycle
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        odata_reg[p] <= gpx_pkg::RST_HALF;
      end else if (psel && ofs == gpx_pkg::OFS_ODATA) begin
        odata_reg[p] <= wdata[15:0];
      end else if (psel && ofs == gpx_pkg::OFS_TOGGLE) begin
        odata_reg[p] <= odata_reg[p] ^ wdata[15:0];
      end
    end

    // ************************************************************
    // lock sequence
    // ************************************************************
    // a wrong step drops back to idle, so a stray write cannot half-arm the lock
    // key: write 1, then 0, then 1 on the key bit with the same pin mask
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        lk_reg <= gpx_pkg::GPX_LK_IDLE;
        lck_reg[p] <= gpx_pkg::RST_HALF;
        lck_act_reg[p] <= 1'b0;
      end else if (psel && ofs == gpx_pkg::OFS_LOCK && !lck_act_reg[p]) begin
        case (lk_reg)
          gpx_pkg::GPX_LK_IDLE: begin
            if (wdata[gpx_pkg::LOCK_KEY]) begin
              lk_reg <= gpx_pkg::GPX_LK_ONE;
              lck_reg[p] <= wdata[15:0];
            end
          end
          gpx_pkg::GPX_LK_ONE: begin
            if (!wdata[gpx_pkg::LOCK_KEY] && wdata[15:0] == lck_reg[p]) begin
              lk_reg <= gpx_pkg::GPX_LK_ZERO;
            end else begin
              lk_reg <= gpx_pkg::GPX_LK_IDLE;
            end
          end
          gpx_pkg::GPX_LK_ZERO: begin
            lk_reg <= gpx_pkg::GPX_LK_IDLE;
            if (wdata[gpx_pkg::LOCK_KEY] && wdata[15:0] == lck_reg[p]) begin
              lck_act_reg[p] <= 1'b1;
            end
          end
          default: begin
            lk_reg <= gpx_pkg::GPX_LK_IDLE;
          end
        endcase
      end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    for (genvar b = 0; b < P; b++) begin : g_pin
      logic [1:0] md;
      logic [3:0] afs;
      logic ad;
      logic ae;
      logic drv;
      logic val;
      assign md = mode_reg[p][2*b +: 2];
      assign afs = (b < 8) ? aflo_reg[p][4*(b%8) +: 4] : afhi_reg[p][4*(b%8) +: 4];
      // selections beyond the fitted sources leave the pin undriven
      assign ad = (32'(afs) < NALT) ? alt_out[(p*P+b)*NALT + 32'(afs)] : 1'b0;
      assign ae = (32'(afs) < NALT) ? alt_oe[(p*P+b)*NALT + 32'(afs)] : 1'b0;
      assign val = (md == gpx_pkg::MODE_ALT) ? ad : odata_reg[p][b];
      assign drv = (md == gpx_pkg::MODE_OUT) || (md == gpx_pkg::MODE_ALT && ae);
      assign pin_out[p*P+b] = val;
      // open drain only ever pulls low
      assign pin_oe[p*P+b] = drv && (!otype_reg[p][b] || !val);
      // analog mode cuts both pulls so the pad carries no bias
      assign pull_up_en[p*P+b] = md != gpx_pkg::MODE_ANA && pull_reg[p][2*b +: 2] == gpx_pkg::PULL_UP;
      assign pull_dn_en[p*P+b] = md != gpx_pkg::MODE_ANA && pull_reg[p][2*b +: 2] == gpx_pkg::PULL_DN;
    end
  end

  // ************************************************************
  // external line controller
  // ************************************************************
  logic esel;
  logic [22:0] imask_reg;
  logic [22:0] emask_reg;
  logic [22:0] rise_reg;
  logic [22:0] fall_reg;
  logic [22:0] pend_reg;
  logic [22:0] pend_next;
  logic [22:0] prev_reg;
  logic [22:0] evt_reg;
  logic [31:0] srclo_reg;
  logic [31:0] srchi_reg;
  logic [22:0] line_in;
  logic [22:0] hit;
  assign esel = wr && ext_sel;

  // masks: interrupt and event paths are gated apart
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      imask_reg <= gpx_pkg::RST_LINE;
      emask_reg <= gpx_pkg::RST_LINE;
    end else if (esel) begin
      if (ofs == gpx_pkg::OFS_IMASK) imask_reg <= wdata[22:0];
      if (ofs == gpx_pkg::OFS_EMASK) emask_reg <= wdata[22:0];
    end
  end

  // trigger edges; both bits set on a line gives both edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rise_reg <= gpx_pkg::RST_LINE;
      fall_reg <= gpx_pkg::RST_LINE;
    end else if (esel) begin
      if (ofs == gpx_pkg::OFS_RISE) rise_reg <= wdata[22:0];
      if (ofs == gpx_pkg::OFS_FALL) fall_reg <= wdata[22:0];
    end
  end

  // port choice for the pin-fed lines; a change may itself look like an edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      srclo_reg <= gpx_pkg::RST_WORD;
      srchi_reg <= gpx_pkg::RST_WORD;
    end else if (esel) begin
      if (ofs == gpx_pkg::OFS_SRCLO) srclo_reg <= wdata;
      if (ofs == gpx_pkg::OFS_SRCHI) srchi_reg <= wdata;
    end
  end

  for (genvar i = 0; i < gpx_pkg::NLINE; i++) begin : g_line
    if (i < gpx_pkg::NGPIO_LINE) begin : g_gpio
      logic [3:0] s;
      assign s = (i < 8) ? srclo_reg[4*(i%8) +: 4] : srchi_reg[4*(i%8) +: 4];
      // same bit position of the chosen port
      assign line_in[i] = (32'(s) < NPORT) ? pin_in[32'(s)*P + i] : 1'b0;
    end else begin : g_int
      assign line_in[i] = int_evt[i-gpx_pkg::NGPIO_LINE];
    end
  end

  // ************************************************************
  // edge detection
  // ************************************************************
  // every sample is compared with the previous one, so a high lasting a
  // single cycle still yields both edges; sub-cycle glitches need the
  // source to stretch them into at least one sampled cycle
  assign hit = (rise_reg & line_in & ~prev_reg) | (fall_reg & ~line_in & prev_reg);

  // ************************************************************
  // pending and requests
  // ************************************************************
  // a new request wins over a clear written in the same cycle
  assign pend_next = (pend_reg & ~((esel && ofs == gpx_pkg::OFS_PEND) ? wdata[22:0] : gpx_pkg::RST_LINE))
                     | (hit & imask_reg);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_reg <= gpx_pkg::RST_LINE;
      pend_reg <= gpx_pkg::RST_LINE;
      evt_reg <= gpx_pkg::RST_LINE;
    end else begin
      prev_reg <= line_in;
      pend_reg <= pend_next;
      evt_reg <= hit & emask_reg;
    end
  end

  assign irq_req = pend_reg & imask_reg;
  assign evt_req = evt_reg;

  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] rd_next;
  logic [31:0] rdata_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (ext_sel) begin
      case (ofs)
        gpx_pkg::OFS_IMASK: rd_next = {9'h000, imask_reg};
        gpx_pkg::OFS_EMASK: rd_next = {9'h000, emask_reg};
        gpx_pkg::OFS_RISE: rd_next = {9'h000, rise_reg};
        gpx_pkg::OFS_FALL: rd_next = {9'h000, fall_reg};
        gpx_pkg::OFS_PEND: rd_next = {9'h000, pend_reg};
        gpx_pkg::OFS_SRCLO: rd_next = srclo_reg;
        gpx_pkg::OFS_SRCHI: rd_next = srchi_reg;
        default: rd_next = 32'h0000_0000;
      endcase
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (port_idx == 4'(p)) begin
          case (ofs)
            gpx_pkg::OFS_MODE: rd_next = mode_reg[p];
            gpx_pkg::OFS_OTYPE: rd_next = {16'h0000, otype_reg[p]};
            gpx_pkg::OFS_PULL: rd_next = pull_reg[p];
            gpx_pkg::OFS_ODATA: rd_next = {16'h0000, odata_reg[p]};
            gpx_pkg::OFS_IDATA: rd_next = {16'h0000, pin_in[p*P +: P]};
            gpx_pkg::OFS_AFLO: rd_next = aflo_reg[p];
            gpx_pkg::OFS_AFHI: rd_next = afhi_reg[p];
            gpx_pkg::OFS_LOCK: rd_next = {14'h0000, lck_act_reg[p], 1'b0, lck_reg[p]};
            default: rd_next = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= gpx_pkg::RST_WORD;
    end else if (rd) begin
      rdata_reg <= rd_next;
    end else begin
      rdata_reg <= gpx_pkg::RST_WORD;
    end
  end

  // the slot reads zero outside the cycle after a read, so stale data never linger
  assign rdata = rdata_reg;
endmodule

// ==== bench/gpx_board.sv ====
// Purpose: board model that sets the pin levels seen by the device
// Assumes: the board drives every pin weakly
// Notes: combinational, so a pin reads back what the device drives
`timescale 1ns/1ps
module gpx_board #(
  parameter int N = 96
) (
  // device side
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  input wire logic [N-1:0] pull_up_en,
  input wire logic [N-1:0] pull_dn_en,
  output logic [N-1:0] pin_in,
  // board side
  input wire logic [N-1:0] ext_lvl
);
  // device drive beats pulls, pulls beat the weak board level
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : pull_up_en[i] ? 1'b1 : pull_dn_en[i] ? 1'b0 : ext_lvl[i];
    end
  end
endmodule

// ==== bench/gpx_sva.sv ====
// Purpose: port-level checks of the gpio ports and line controller
// Assumes: internal event inputs stay low while reset is held
// Notes: lines fed from pins are left to the bench, their source is a register
`timescale 1ns/1ps
module gpx_sva #(
  parameter int NPORT = 6,
  parameter int NALT = 4
) (
  // clock, reset and register port
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // pins and alternate sources
  input wire logic [NPORT*16-1:0] pin_out,
  input wire logic [NPORT*16-1:0] pin_oe,
  input wire logic [NPORT*16-1:0] pull_up_en,
  input wire logic [NPORT*16-1:0] pull_dn_en,
  input wire logic [NPORT*16*NALT-1:0] alt_out,
  input wire logic [NPORT*16*NALT-1:0] alt_oe,
  // lines
  input wire logic [6:0] int_evt,
  input wire logic [22:0] irq_req,
  input wire logic [22:0] evt_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_out_src; $changed(pin_out) |-> $past(wr) || $changed(alt_out) || $changed(alt_oe); endproperty
  a_out_src: assert property (p_out_src) else $error("pin output moved without cause");
  property p_oe_src; $changed(pin_oe) |-> $past(wr) || $changed(alt_out) || $changed(alt_oe); endproperty
  a_oe_src: assert property (p_oe_src) else $error("pin enable moved without cause");
  property p_pu; $changed(pull_up_en) |-> $past(wr); endproperty
  a_pu: assert property (p_pu) else $error("pull-up moved without a write");
  property p_pd; $changed(pull_dn_en) |-> $past(wr); endproperty
  a_pd: assert property (p_pd) else $error("pull-down moved without a write");
  property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  for (genvar k = 0; k < 7; k++) begin : g_ln
    property p_evt_edge; evt_req[16+k] |-> $past(int_evt[k]) != $past(int_evt[k], 2); endproperty
    a_evt_edge: assert property (p_evt_edge) else $error("event without an edge");
    property p_pend_set; $rose(irq_req[16+k]) |-> $past(wr) || $past(int_evt[k]) != $past(int_evt[k], 2); endproperty
    a_pend_set: assert property (p_pend_set) else $error("request rose without cause");
    property p_pend_hold; $fell(irq_req[16+k]) |-> $past(wr); endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("request fell without a write");
  end
  c_read: cover property (rd ##1 rdata != 32'h0);
  c_evt: cover property (evt_req != 23'h0);
  c_clear: cover property ($fell(irq_req[16]));
  c_drive: cover property (pin_oe != '0);
endmodule
bind gpx_top gpx_sva #(.NPORT(NPORT), .NALT(NALT)) u_sva (.clk, .rstn, .wr, .rd, .rdata, .pin_out, .pin_oe,
  .pull_up_en, .pull_dn_en, .alt_out, .alt_oe, .int_evt, .irq_req, .evt_req);

// ==== bench/gpx_top_tb.sv ====
// Purpose: self-checking bench of the gpio ports and line controller
// Assumes: port 2 stays input without pulls, so the board sets its levels
// Notes: the register image models lock only for 1- and 2-bit pin fields
`timescale 1ns/1ps
module gpx_top_tb;
  localparam int NP = 6;
  localparam int NA = 4;
  localparam int N = NP * 16;
  localparam int LB = 256;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [N-1:0] pin_in, pin_out, pin_oe, pu, pd;
  logic [N*NA-1:0] alt_out = '0;
  logic [N*NA-1:0] alt_oe = '0;
  logic [6:0] int_evt = 7'h00;
  logic [22:0] irq_req, evt_req;
  logic [N-1:0] ext_lvl = '0;
  logic [31:0] mdl [1024];
  int lks [NP];
  logic [15:0] lkm [NP];
  logic [NP-1:0] lkd = '0;
  logic [31:0] lk_seq [6] = '{32'h1_0001, 32'h1_0001, 32'h1, 32'h1_0001, 32'h1, 32'h1_0001};
  int lines [5] = '{5, 16, 17, 18, 19};
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  gpx_top #(.NPORT(NP), .NALT(NA)) dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe,
    .pull_up_en(pu), .pull_dn_en(pd), .alt_out, .alt_oe, .int_evt, .irq_req, .evt_req);
  gpx_board #(.N(N)) board (.pin_out, .pin_oe, .pull_up_en(pu), .pull_dn_en(pd), .pin_in, .ext_lvl);
  // ****
  // register image
  // ****
  task automatic m_wr(input logic [11:0] a, input logic [31:0] d);
    int p;
    logic [31:0] km;
    p = int'(a[9:6]);
    km = '0;
    if (a[10]) begin
      if (a[5:0] == gpx_pkg::OFS_PEND) mdl[LB+4] &= ~d;
      else if (a[5:0] < gpx_pkg::OFS_PEND) mdl[a[11:2]] = d & 32'h007f_ffff;
      else if (a[5:0] <= gpx_pkg::OFS_SRCHI) mdl[a[11:2]] = d;
    end else if (p < NP) begin
      case (a[5:0])
        gpx_pkg::OFS_TOGGLE: mdl[a[11:2] - 2] ^= d;
        gpx_pkg::OFS_ODATA: mdl[a[11:2]] = d;
        gpx_pkg::OFS_IDATA: ;
        gpx_pkg::OFS_LOCK: if (!lkd[p]) begin
          if (lks[p] == 1) lks[p] = (!d[16] && d[15:0] == lkm[p]) ? 2 : 0;
          else if (lks[p] == 2) begin
            lkd[p] = d[16] && d[15:0] == lkm[p];
            lks[p] = 0;
          end else begin
            lks[p] = d[16] ? 1 : 0;
            lkm[p] = d[15:0];
          end
          mdl[a[11:2]] = {14'h0, lkd[p], 17'h0};
        end
        default: if (a[5:0] <= gpx_pkg::OFS_AFHI) begin
          for (int i = 0; i < 16; i++) if (lkd[p] && lkm[p][i]) km |= (a[3:0] == 4'h4 ? 32'h1 : 32'h3) << (i * (a[3:0] == 4'h4 ? 1 : 2));
          mdl[a[11:2]] = (mdl[a[11:2]] & km) | (d & ~km);
        end
      endcase
    end
  endtask
  // ****
  // bus and compare
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    m_wr(a, d);
  endtask
  task automatic br(input logic [11:0] a, input logic [31:0] m);
    logic [31:0] e;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    e = (!a[10] && a[5:0] == gpx_pkg::OFS_IDATA && a[9:6] < NP) ? 32'(pin_in[a[9:6]*16 +: 16]) : mdl[a[11:2]];
    #1;
    chk(rdata & m, e & m);
  endtask
  // flips one line; lines below 16 come from port 2
  task automatic lset(input int n);
    logic v;
    logic hit;
    v = n < 16 ? ~ext_lvl[32 + n] : ~int_evt[n - 16];
    @(posedge clk);
    if (n < 16) ext_lvl[32 + n] <= v;
    else int_evt[n - 16] <= v;
    hit = v ? mdl[LB+2][n] : mdl[LB+3][n];
    if (hit && mdl[LB][n]) mdl[LB+4][n] = 1'b1;
    @(posedge clk);
    #1;
    chk(32'(evt_req[n]), 32'(hit & mdl[LB+1][n]));
    chk(32'(irq_req), mdl[LB+4] & mdl[LB]);
    @(posedge clk);
    #1;
    chk(32'(evt_req[n]), 32'h0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      final_report;
    end
  end
  // ****
  // tests
  // ****
  initial begin
    foreach (mdl[i]) mdl[i] = 32'h0;
    void'($urandom(47396));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    for (int p = 0; p < 8; p++) for (int o = 0; o < 10; o++) br(12'(p * 64 + o * 4), '1);
    for (int o = 0; o < 8; o++) br(12'(12'h400 + o * 4), '1);
    $display("test reset done");
    @(posedge clk);
    ext_lvl <= {$urandom, $urandom, $urandom};
    for (int i = 0; i < N * NA / 32; i++) begin
      alt_out[i*32 +: 32] <= $urandom;
      alt_oe[i*32 +: 32] <= $urandom;
    end
    for (int o = 0; o < 8; o++) bw(12'(12'h040 + o * 4), (o == 1 || o == 3 || o == 5) ? $urandom & 32'hffff : $urandom);
    bw(12'h064, $urandom);
    for (int o = 0; o < 10; o++) br(12'(12'h040 + o * 4), '1);
    for (int i = 0; i < 16; i++) begin
      chk(32'({pu[16+i], pd[16+i]}),
        32'({mdl[16][2*i +: 2] != gpx_pkg::MODE_ANA && mdl[18][2*i +: 2] == gpx_pkg::PULL_UP,
        mdl[16][2*i +: 2] != gpx_pkg::MODE_ANA && mdl[18][2*i +: 2] == gpx_pkg::PULL_DN}));
    end
    bw(12'h000, 32'h91);
    bw(12'h004, 32'h4);
    bw(12'h008, 32'h204);
    bw(12'h018, 32'h2000);
    bw(12'h00c, 32'h5);
    #1;
    chk(32'({pin_out[0], pin_oe[0], pin_oe[2], pu[1], pd[4], pin_out[3], pin_oe[3]}),
      32'({5'b11011, alt_out[14], alt_oe[14]}));
    bw(12'h014, 32'h5);
    #1;
    chk(32'({pin_out[0], pin_oe[2]}), 32'h1);
    $display("test pins done");
    for (int i = 0; i < 6; i++) begin
      bw(12'h020, lk_seq[i]);
      if (i == 2 || i == 5) br(12'h020, 32'h2_0000);
    end
    bw(12'h000, 32'h0);
    bw(12'h020, 32'h0);
    br(12'h000, '1);
    br(12'h020, 32'h2_0000);
    $display("test lock done");
    bw(12'h414, 32'h0020_0000);
    bw(12'h408, 32'h0015_0020);
    bw(12'h40c, 32'h0006_0000);
    bw(12'h404, $urandom);
    bw(12'h400, 32'h0077_ffff);
    foreach (lines[i]) repeat (2) lset(lines[i]);
    @(posedge clk);
    int_evt[4] <= 1'b1;
    @(posedge clk);
    int_evt[4] <= 1'b0;
    mdl[LB+4][20] = 1'b1;
    br(12'h410, '1);
    bw(12'h410, $urandom);
    br(12'h410, '1);
    chk(32'(irq_req), mdl[LB+4] & mdl[LB]);
    bw(12'h400, 32'h0);
    #1;
    chk(32'(irq_req), 32'h0);
    br(12'h410, '1);
    $display("test lines done");
    final_report;
  end
endmodule
